// file: inc/flic_pkg.sv
// Package of constants and types for the four-level interrupt controller.
// Contract
// - Six sources; each level is its high-register bit joined with its low-register bit.
// - High/low bits 00 level 0 lowest, 01 level 1, 10 level 2, 11 level 3.
// - Accept an enabled pending request when no equal or higher level is in service.
// - Requests at or below the level in service wait until that service completes.
// - A higher level preempts; nesting of up to four levels is tracked.
// - Same-level ties go ext0, timer0, ext1, timer1, serial, timer2.
// - Vectors are 03h, 0bh, 13h, 1bh, 23h and 2bh in polling order.
// - Vectoring clears edge-mode external flags and timer 0/1 flags, never serial or timer 2.
// - Enable register: bit 7 global, bit 6 reserved, bits 5..0 per source enables.
// - The high-priority register sits at special-function address b7h.
package flic_pkg;
   localparam int NUM_SRC = 6;
   localparam int NUM_LVL = 4;
   localparam logic [7:0] ADDR_ENABLE = 8'ha8;
   localparam logic [7:0] ADDR_PRIO_LOW = 8'hb8;
   localparam logic [7:0] ADDR_PRIO_HIGH = 8'hb7;
   localparam int BIT_GLOBAL_EN = 7;
   localparam int BIT_RESERVED = 6;
   localparam logic [7:0] RESET_ENABLE = 8'h00;
   localparam logic [7:0] RESET_PRIO = 8'h00;
   localparam logic [7:0] VEC_BASE = 8'h03;
   localparam logic [7:0] VEC_STEP = 8'h08;
   localparam int SRC_EXT0 = 0;
   localparam int SRC_TMR0 = 1;
   localparam int SRC_EXT1 = 2;
   localparam int SRC_TMR1 = 3;
   localparam int SRC_SER = 4;
   localparam int SRC_TMR2 = 5;
   typedef enum logic [1:0] {
      FLIC_IDLE = 2'b01,
      FLIC_ACK = 2'b10
   } flic_state_e;
endpackage : flic_pkg

// file: src/flic_sfr_bank.sv
`timescale 1ns/1ps
// Special-function register bank holding enable and priority registers.
module flic_sfr_bank (
   input wire logic clk,
   input wire logic rstn,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   output logic [7:0] interrupt_enable_reg,
   output logic [7:0] priority_low_reg,
   output logic [7:0] priority_high_reg
);
   logic [7:0] next_ie;
   logic [7:0] next_ipl;
   logic [7:0] next_iph;
   logic [7:0] next_rdata;
   logic next_hit;

   always_comb begin
      next_ie = interrupt_enable_reg;
      next_ipl = priority_low_reg;
      next_iph = priority_high_reg;
      next_rdata = sfr_rdata;
      next_hit = 1'b0;
      if (sfr_wr) begin
         case (sfr_addr)
            // The reserved bit is not implemented and always reads zero.
            flic_pkg::ADDR_ENABLE: next_ie = sfr_wdata & ~(8'h01 << flic_pkg::BIT_RESERVED);
            flic_pkg::ADDR_PRIO_LOW: next_ipl = {2'h0, sfr_wdata[5:0]};
            flic_pkg::ADDR_PRIO_HIGH: next_iph = {2'h0, sfr_wdata[5:0]};
            default: next_ie = interrupt_enable_reg;
         endcase
      end
      if (sfr_rd) begin
         next_hit = 1'b1;
         case (sfr_addr)
            flic_pkg::ADDR_ENABLE: next_rdata = interrupt_enable_reg;
            flic_pkg::ADDR_PRIO_LOW: next_rdata = priority_low_reg;
            flic_pkg::ADDR_PRIO_HIGH: next_rdata = priority_high_reg;
            default: begin
               next_rdata = 8'h00;
               next_hit = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         interrupt_enable_reg <= flic_pkg::RESET_ENABLE;
         priority_low_reg <= flic_pkg::RESET_PRIO;
         priority_high_reg <= flic_pkg::RESET_PRIO;
         sfr_rdata <= 8'h00;
         sfr_hit <= 1'b0;
      end else begin
         interrupt_enable_reg <= next_ie;
         priority_low_reg <= next_ipl;
         priority_high_reg <= next_iph;
         sfr_rdata <= next_rdata;
         sfr_hit <= next_hit;
      end
   end
endmodule : flic_sfr_bank

// file: src/flic_top.sv
`timescale 1ns/1ps
// Six-source, four-level nested interrupt controller facing the core.
module flic_top (
   input wire logic clk,
   input wire logic rstn,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   input wire logic ext_int0_flag,
   input wire logic timer0_overflow_flag,
   input wire logic ext_int1_flag,
   input wire logic timer1_overflow_flag,
   input wire logic receive_done_flag,
   input wire logic transmit_done_flag,
   input wire logic timer2_overflow_flag,
   input wire logic timer2_external_flag,
   input wire logic ext_int0_edge_mode,
   input wire logic ext_int1_edge_mode,
   output logic irq_req,
   output logic [7:0] irq_vector,
   input wire logic irq_ack,
   input wire logic irq_return,
   output logic clr_ext_int0_flag,
   output logic clr_timer0_overflow_flag,
   output logic clr_ext_int1_flag,
   output logic clr_timer1_overflow_flag,
   output logic [3:0] in_service
);
   logic [7:0] interrupt_enable_reg;
   logic [7:0] priority_low_reg;
   logic [7:0] priority_high_reg;
   logic [5:0] pend;
   logic [1:0] lvl [6];
   logic found;
   logic [2:0] win_src;
   logic [1:0] win_lvl;
   flic_pkg::flic_state_e state;
   flic_pkg::flic_state_e next_state;
   logic [2:0] sel_src;
   logic [2:0] next_sel_src;
   logic [3:0] next_in_service;
   logic next_irq_req;
   logic [7:0] next_irq_vector;
   logic [3:0] next_clr;

   flic_sfr_bank u_bank (
      .clk(clk),
      .rstn(rstn),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata),
      .sfr_hit(sfr_hit),
      .interrupt_enable_reg(interrupt_enable_reg),
      .priority_low_reg(priority_low_reg),
      .priority_high_reg(priority_high_reg)
   );

   // Vector address of a source index in polling order.
   function automatic logic [7:0] vec_of(input logic [2:0] src);
      vec_of = flic_pkg::VEC_BASE + 8'(src) * flic_pkg::VEC_STEP;
   endfunction : vec_of

   // True when any level at or above lv is marked in service.
   function automatic logic blocked(input logic [3:0] isr, input logic [1:0] lv);
      blocked = (isr >> lv) != 4'h0;
   endfunction : blocked

   always_comb begin
      pend[flic_pkg::SRC_EXT0] = ext_int0_flag;
      pend[flic_pkg::SRC_TMR0] = timer0_overflow_flag;
      pend[flic_pkg::SRC_EXT1] = ext_int1_flag;
      pend[flic_pkg::SRC_TMR1] = timer1_overflow_flag;
      pend[flic_pkg::SRC_SER] = receive_done_flag | transmit_done_flag;
      pend[flic_pkg::SRC_TMR2] = timer2_overflow_flag | timer2_external_flag;
      pend = pend & interrupt_enable_reg[5:0]
         & {6{interrupt_enable_reg[flic_pkg::BIT_GLOBAL_EN]}};
      for (int i = 0; i < flic_pkg::NUM_SRC; i++) begin
         lvl[i] = {priority_high_reg[i], priority_low_reg[i]};
      end
   end

   // Highest level wins; within a level the lowest index wins because later
   // sources must strictly beat the current pick.
   always_comb begin
      found = 1'b0;
      win_src = 3'h0;
      win_lvl = 2'h0;
      for (int i = 0; i < flic_pkg::NUM_SRC; i++) begin
         if (pend[i] && (!found || lvl[i] > win_lvl)) begin
            found = 1'b1;
            win_src = 3'(i);
            win_lvl = lvl[i];
         end
      end
   end

   always_comb begin
      next_state = state;
      next_sel_src = sel_src;
      next_in_service = in_service;
      next_irq_req = 1'b0;
      next_irq_vector = irq_vector;
      next_clr = 4'h0;
      // Return retires the topmost level, and no new request is accepted in the same cycle.
      if (irq_return) begin
         if (in_service[3]) next_in_service[3] = 1'b0;
         else if (in_service[2]) next_in_service[2] = 1'b0;
         else if (in_service[1]) next_in_service[1] = 1'b0;
         else next_in_service[0] = 1'b0;
      end
      case (state)
         flic_pkg::FLIC_IDLE: begin
            if (found && !irq_return && !blocked(in_service, win_lvl)) begin
               next_state = flic_pkg::FLIC_ACK;
               next_sel_src = win_src;
               next_irq_req = 1'b1;
               next_irq_vector = vec_of(win_src);
            end
         end
         flic_pkg::FLIC_ACK: begin
            next_irq_req = 1'b1;
            // The core vectors only on acknowledge, so the level is marked then.
            if (irq_ack) begin
               next_irq_req = 1'b0;
               next_state = flic_pkg::FLIC_IDLE;
               next_in_service[lvl[sel_src]] = 1'b1;
               case (sel_src)
                  3'(flic_pkg::SRC_EXT0): next_clr[0] = ext_int0_edge_mode;
                  3'(flic_pkg::SRC_TMR0): next_clr[1] = 1'b1;
                  3'(flic_pkg::SRC_EXT1): next_clr[2] = ext_int1_edge_mode;
                  3'(flic_pkg::SRC_TMR1): next_clr[3] = 1'b1;
                  default: next_clr = 4'h0;
               endcase
            end
         end
         default: next_state = flic_pkg::FLIC_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state <= flic_pkg::FLIC_IDLE;
         sel_src <= 3'h0;
         in_service <= 4'h0;
         irq_req <= 1'b0;
         irq_vector <= 8'h00;
         clr_ext_int0_flag <= 1'b0;
         clr_timer0_overflow_flag <= 1'b0;
         clr_ext_int1_flag <= 1'b0;
         clr_timer1_overflow_flag <= 1'b0;
      end else begin
         state <= next_state;
         sel_src <= next_sel_src;
         in_service <= next_in_service;
         irq_req <= next_irq_req;
         irq_vector <= next_irq_vector;
         clr_ext_int0_flag <= next_clr[0];
         clr_timer0_overflow_flag <= next_clr[1];
         clr_ext_int1_flag <= next_clr[2];
         clr_timer1_overflow_flag <= next_clr[3];
      end
   end
endmodule : flic_top

// file: verification/flic_periph.sv
// Peripheral flag model on the far side of the interrupt controller.
`timescale 1ns/1ps
module flic_periph (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] raise,
   input wire logic [7:0] lower,
   input wire logic [3:0] clr,
   output logic [7:0] flags
);
   // Only a clear pulse or a software lower drops a flag, so a missed clear re-requests.
   always_ff @(posedge clk) flags <= !rstn ? 8'h00 : (flags | raise) & ~lower & ~{4'h0, clr};
endmodule : flic_periph

// file: verification/flic_properties.sv
// Port-level checks of the interrupt controller.
`timescale 1ns/1ps
module flic_properties (
   input wire logic clk,
   input wire logic rstn,
   input wire logic irq_req,
   input wire logic [7:0] irq_vector,
   input wire logic irq_ack,
   input wire logic irq_return,
   input wire logic [3:0] in_service
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   a_ack_drop: assert property (irq_req && irq_ack |=> !irq_req) else $error("req kept");
   a_win_held: assert property (irq_req && !irq_ack |=> irq_req && $stable(irq_vector))
      else $error("winner moved");
   a_vec_form: assert property (irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector < 8'h30)
      else $error("bad vector");
   a_ack_marks: assert property (irq_req && irq_ack |=> in_service > $past(in_service))
      else $error("no mark");
   a_one_mark: assert property (irq_req && irq_ack |=>
      $countones(in_service) == 1 + $countones($past(in_service))) else $error("mark count");
   a_ret_drop: assert property (irq_return && !irq_ack && in_service != 4'h0 |=>
      in_service < $past(in_service)) else $error("no retire");
   a_ret_block: assert property (irq_return && !irq_req |=> !irq_req) else $error("rose");
   a_top_block: assert property ($rose(irq_req) |-> !in_service[3]) else $error("over top");
endmodule : flic_properties
bind flic_top flic_properties u_props (.clk, .rstn, .irq_req, .irq_vector, .irq_ack, .irq_return,
   .in_service);

// file: verification/testbench.sv
// Bench driving the interrupt controller through its scenarios.
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, rstn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, irq_ack = 1'b0;
   logic irq_return = 1'b0, em0 = 1'b0, em1 = 1'b1, sfr_hit, irq_req;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, raise = 8'h00, lower = 8'h00, f;
   logic [7:0] sfr_rdata, irq_vector;
   logic [3:0] in_service, c;
   int n_fail = 0, n_tests = 0, cyc = 0;
   always #12.5 clk = ~clk;
   flic_top u_dut (.clk, .rstn, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .sfr_hit,
      .ext_int0_flag(f[0]), .timer0_overflow_flag(f[1]), .ext_int1_flag(f[2]),
      .timer1_overflow_flag(f[3]), .receive_done_flag(f[4]), .transmit_done_flag(f[5]),
      .timer2_overflow_flag(f[6]), .timer2_external_flag(f[7]), .ext_int0_edge_mode(em0),
      .ext_int1_edge_mode(em1), .irq_req, .irq_vector, .irq_ack, .irq_return, .in_service,
      .clr_ext_int0_flag(c[0]), .clr_timer0_overflow_flag(c[1]), .clr_ext_int1_flag(c[2]),
      .clr_timer1_overflow_flag(c[3]));
   flic_periph u_periph (.clk, .rstn, .raise, .lower, .clr(c), .flags(f));
   task automatic end_of_test;
      if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) n_fail++;
      if (got !== exp) $display("unexpected %0t %h %h", $time, got, exp);
   endtask : chk
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      {sfr_wr, sfr_rd} <= {w, !w};
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge clk);
      {sfr_wr, sfr_rd} <= 2'b00;
      @(posedge clk);
      if (!w) chk(sfr_rdata, d);
      if (!w) chk({7'h00, sfr_hit}, {7'h00, a == 8'ha8 || a == 8'hb7 || a == 8'hb8});
   endtask : acc
   task automatic serve(input logic [7:0] up, vec, input int b, input logic keep);
      raise <= up;
      @(posedge clk);
      raise <= 8'h00;
      for (int i = 0; i < 20 && irq_req !== 1'b1; i++) @(posedge clk);
      chk(irq_vector, vec);
      irq_ack <= 1'b1;
      @(posedge clk);
      irq_ack <= 1'b0;
      repeat (2) @(posedge clk);
      chk({7'h00, f[b]}, {7'h00, keep});
      lower <= 8'h01 << b;
      @(posedge clk);
      lower <= 8'h00;
   endtask : serve
   task automatic ret(input logic [3:0] e);
      irq_return <= 1'b1;
      @(posedge clk);
      irq_return <= 1'b0;
      @(posedge clk);
      chk({4'h0, in_service}, {4'h0, e});
   endtask : ret
   task automatic t_order;
      raise <= 8'h5f;
      @(posedge clk);
      raise <= 8'h00;
      acc(1'b1, 8'hb7, 8'hff);
      acc(1'b0, 8'hb7, 8'h3f);
      acc(1'b0, 8'h42, 8'h00);
      acc(1'b1, 8'ha8, 8'h7f);
      acc(1'b0, 8'ha8, 8'h3f);
      chk({7'h00, irq_req}, 8'h00);
      acc(1'b1, 8'ha8, 8'hff);
      for (int k = 0; k < 6; k++) begin
         serve(8'h00, 8'(3 + 8 * k), k < 5 ? k : 6, k == 0 || k > 3);
         ret(4'h0);
      end
   endtask : t_order
   task automatic t_nest;
      em0 <= 1'b1;
      em1 <= 1'b0;
      acc(1'b1, 8'hb7, 8'h0c);
      acc(1'b1, 8'hb8, 8'h0a);
      serve(8'h01, 8'h03, 0, 1'b0);
      serve(8'h06, 8'h13, 2, 1'b1);
      serve(8'h08, 8'h1b, 3, 1'b0);
      ret(4'h5);
      ret(4'h1);
      serve(8'h00, 8'h0b, 1, 1'b0);
      ret(4'h1);
   endtask : t_nest
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      t_order();
      t_nest();
      end_of_test();
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) n_fail++;
      if (cyc == 3000) end_of_test();
   end
endmodule : testbench
